// ===== src/i2e_top.sv
// error detection, dma requests and low-power control of the bus controller
// Functional notes
// - no-stretch slave, byte into full receive register: drop it, nack, overrun.
// - no-stretch slave, first byte after stop: send loaded transmit byte, else all ones.
// - no-stretch slave, transmit register empty when due: send 0xff, overrun.
// - overrun sets its status flag and the error interrupt if enabled.
// - received check byte unequal to computed value gets a nack.
// - check mismatch sets its flag and the error interrupt if enabled.
// - idle select clear: clock low for low limit gives timeout.
// - idle select set: both lines high for low limit gives timeout.
// - master cumulative clock extension reaching extend limit gives timeout.
// - slave cumulative clock extension reaching extend limit gives timeout.
// - timeout as master requests an automatic stop condition.
// - timeout as slave releases both bus lines.
// - timeout sets its flag and the error interrupt if enabled.
// - host mode and pin detect on: falling notify edge sets alert flag.
// - transmit dma enabled: request whenever transmit-ready is set.
// - receive dma enabled: request whenever receive-full is set, check byte too.
// - transfer end and check byte slot come from the internal byte counter.
// - debug halt freezes or runs the timeout counters, per a config bit.
// - registers kept in stop; enabled wakeup on internal oscillator wakes on match.
// - block off releases lines and returns state and flags to reset.
`timescale 1ns/1ps
module i2e_top
   import i2e_pkg::*;
#(
   parameter int unsigned LIMIT_W = 12,
   parameter int unsigned COUNT_W = 8
) (
   input  logic              mclk,          // kernel clock
   input  logic              nrst,          // async reset, active low
   input  logic [ADDR_W-1:0] reg_addr,      // register byte address
   input  logic [DATA_W-1:0] reg_wdata,     // register write data
   input  logic              reg_wr,        // write strobe
   input  logic              reg_rd,        // read strobe
   output logic [DATA_W-1:0] reg_rdata,     // read data, cycle after strobe
   input  logic              scl_in,        // clock line level
   input  logic              sda_in,        // data line level
   input  logic              notify_pin,    // sideband_notify_pin level
   input  logic              is_master,     // engine acts as master
   input  logic              is_slave,      // engine is addressed slave
   input  logic              start_stb,     // transfer starts, load counter
   input  logic              byte_rx_stb,   // a byte was received
   input  logic [BYTE_W-1:0] rx_byte,       // received byte
   input  logic [BYTE_W-1:0] pec_value,     // computed check value
   input  logic              tx_req,        // transmitter wants data
   input  logic              tx_due_stb,    // a data byte must be sent now
   input  logic              stop_detected, // stop_detected_flag
   input  logic              stretch_ext,   // device holds clock low
   input  logic              dbg_halt,      // processor halted
   input  logic              stop_mode,     // system in stop mode
   input  logic              osc_internal,  // clocked by internal_rc_osc
   input  logic              addr_match_stb,// address recognised
   output logic [BYTE_W-1:0] tx_byte,       // byte to send
   output logic              tx_byte_stb,   // tx_byte valid, one cycle
   output logic              force_nack,    // nack this byte, one cycle
   output logic              auto_stop,     // request stop, one cycle
   output logic              lines_release, // release data and clock lines
   output logic              pec_slot,      // next byte is the check byte
   output logic              xfer_done,     // byte counter exhausted
   output logic              err_irq,       // error interrupt
   output logic              tx_dma_req,    // transmit dma request
   output logic              rx_dma_req,    // receive dma request
   output logic              wake_req       // stop mode wakeup, one cycle
);
   // =====================================================================
   // state
   // =====================================================================
   typedef struct packed {
      logic               on;
      logic               err_ie;
      logic               txdma_en;
      logic               rxdma_en;
      logic               nostr;
      logic               wup_en;
      logic               host_en;
      logic               note_en;
      logic               pec_en;
      logic [COUNT_W-1:0] cnt_cfg;
      logic [LIMIT_W-1:0] low_lim;
      logic               idle_sel;
      logic               low_en;
      logic [LIMIT_W-1:0] ext_lim;
      logic               ext_en;
      logic               dbg_frz;
      logic [BYTE_W-1:0]  rxd;
      logic [BYTE_W-1:0]  txd;
      logic               rx_full;
      logic               tx_empty;
      logic               tx_rdy;
      logic               ovr_f;
      logic               pec_f;
      logic               tout_f;
      logic               alert_f;
      logic [COUNT_W-1:0] cnt;
      logic [UNIT_W-1:0]  presc;
      logic [LIMIT_W-1:0] low_cnt;
      logic [LIMIT_W-1:0] ext_cnt;
      logic               note_prev;
      logic [DATA_W-1:0]  rdata;
      logic [BYTE_W-1:0]  tx_byte;
      logic               tx_stb;
      logic               nack;
      logic               auto_stop;
      logic               rel_hold;
      logic               lines_rel;
      logic               pec_slot;
      logic               done;
      logic               err_irq;
      logic               txdma_req;
      logic               rxdma_req;
      logic               wake;
   } i2e_state_s;

   localparam i2e_state_s ST_RST = '{
      tx_empty:  1'b1,
      note_prev: 1'b1,
      lines_rel: 1'b1,
      done:      1'b1,
      default:   '0
   };

   i2e_state_s s_q;
   i2e_state_s s_d;
   logic [2:0] pins_s;
   logic       scl_s;
   logic       sda_s;
   logic       note_s;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   // =====================================================================
   // pin synchroniser
   // =====================================================================
   i2e_sync #(
      .W (3)
   ) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .din  ({notify_pin, sda_in, scl_in}),
      .dout (pins_s)
   );

   assign scl_s  = pins_s[0];
   assign sda_s  = pins_s[1];
   assign note_s = pins_s[2];

   // =====================================================================
   // next state
   // =====================================================================
   always_comb begin
      logic              tick;
      logic              frz;
      logic              cond_a;
      logic              tout_ev;
      logic              ovr_ev;
      logic              pec_ev;
      logic              alert_ev;
      logic              tx_take;
      logic              rd_rx;
      logic              wr_tx;
      logic [DATA_W-1:0] clr;
      logic [DATA_W-1:0] stat;
      tick     = 1'b0;
      frz      = dbg_halt & s_q.dbg_frz;
      cond_a   = 1'b0;
      tout_ev  = 1'b0;
      ovr_ev   = 1'b0;
      pec_ev   = 1'b0;
      alert_ev = 1'b0;
      tx_take  = 1'b0;
      rd_rx    = reg_rd & hit(reg_addr, OFF_RXD);
      wr_tx    = reg_wr & hit(reg_addr, OFF_TXD);
      clr      = (reg_wr & hit(reg_addr, OFF_CLR)) ? reg_wdata : ZERO_WORD;
      stat     = ZERO_WORD;
      s_d      = s_q;
      s_d.tx_stb    = 1'b0;
      s_d.nack      = 1'b0;
      s_d.auto_stop = 1'b0;
      s_d.wake      = 1'b0;
      s_d.rdata     = ZERO_WORD;

      // configuration writes, kept through stop mode
      if (reg_wr & hit(reg_addr, OFF_CTRL)) begin
         s_d.on       = reg_wdata[CB_ON];
         s_d.err_ie   = reg_wdata[CB_ERROR_IRQ_ENABLE];
         s_d.txdma_en = reg_wdata[CB_TXDMA];
         s_d.rxdma_en = reg_wdata[CB_RXDMA];
         s_d.nostr    = reg_wdata[CB_NOSTR];
         s_d.wup_en   = reg_wdata[CB_WUP];
         s_d.host_en  = reg_wdata[CB_HOST];
         s_d.note_en  = reg_wdata[CB_NOTE];
         s_d.pec_en   = reg_wdata[CB_PEC];
      end
      if (reg_wr & hit(reg_addr, OFF_CNT)) begin
         s_d.cnt_cfg = reg_wdata[COUNT_W-1:0];
      end
      if (reg_wr & hit(reg_addr, OFF_TOUT)) begin
         s_d.low_lim  = reg_wdata[TB_LOW_LSB +: LIMIT_W];
         s_d.idle_sel = reg_wdata[TB_IDLE];
         s_d.low_en   = reg_wdata[TB_LOW_EN];
         s_d.ext_lim  = reg_wdata[TB_EXT_LSB +: LIMIT_W];
         s_d.ext_en   = reg_wdata[TB_EXT_EN];
      end
      if (reg_wr & hit(reg_addr, OFF_DBG)) begin
         s_d.dbg_frz = reg_wdata[DB_FRZ];
      end

      // timeout time base, held while frozen by debug halt
      if (!frz) begin
         if (s_q.presc == UNIT_W'(UNIT_CYC - 1'b1)) begin
            s_d.presc = '0;
            tick      = 1'b1;
         end else begin
            s_d.presc = UNIT_W'(s_q.presc + 1'b1);
         end
      end

      // low or idle timer
      cond_a = s_q.idle_sel ? (scl_s & sda_s) : ~scl_s;
      if (!cond_a) begin
         s_d.low_cnt = '0;
      end else if (tick && s_q.low_cnt != s_q.low_lim) begin
         s_d.low_cnt = LIMIT_W'(s_q.low_cnt + 1'b1);
         if (s_q.low_en && s_d.low_cnt == s_q.low_lim) begin
            tout_ev = 1'b1;
         end
      end

      // cumulative extension timer, restarted by each transfer
      if (start_stb) begin
         s_d.ext_cnt = '0;
      end else if (stretch_ext && (is_master || is_slave) && tick &&
                   s_q.ext_cnt != s_q.ext_lim) begin
         s_d.ext_cnt = LIMIT_W'(s_q.ext_cnt + 1'b1);
         if (s_q.ext_en && s_d.ext_cnt == s_q.ext_lim) begin
            tout_ev = 1'b1;
         end
      end

      // automatic bus actions on timeout
      s_d.auto_stop = tout_ev & is_master;
      if (tout_ev && is_slave) begin
         s_d.rel_hold = 1'b1;
      end

      // receive path
      if (byte_rx_stb) begin
         if (s_q.nostr && is_slave && s_q.rx_full && !rd_rx) begin
            s_d.nack = 1'b1;
            ovr_ev   = 1'b1;
         end else begin
            s_d.rxd = rx_byte;
            if (s_q.pec_slot && rx_byte != pec_value) begin
               s_d.nack = 1'b1;
               pec_ev   = 1'b1;
            end
         end
      end
      if (rd_rx) begin
         s_d.rx_full = 1'b0;
      end
      if (byte_rx_stb && !ovr_ev) begin
         s_d.rx_full = 1'b1;
      end

      // transmit path; the check byte slot is served by the engine
      if (tx_due_stb && !s_q.pec_slot) begin
         if (!s_q.tx_empty) begin
            s_d.tx_byte  = s_q.txd;
            s_d.tx_stb   = 1'b1;
            s_d.tx_empty = 1'b1;
            tx_take      = 1'b1;
         end else if (s_q.nostr && is_slave) begin
            s_d.tx_byte = FILL_BYTE;
            s_d.tx_stb  = 1'b1;
            ovr_ev      = 1'b1;
            tx_take     = 1'b1;
         end
      end
      if (wr_tx) begin
         s_d.txd      = reg_wdata[BYTE_W-1:0];
         s_d.tx_empty = 1'b0;
      end

      // byte counter ends the transfer and places the check byte
      if (start_stb) begin
         s_d.cnt = s_q.cnt_cfg;
      end else if ((byte_rx_stb || tx_take) && s_q.cnt != '0) begin
         s_d.cnt = COUNT_W'(s_q.cnt - 1'b1);
      end
      s_d.done     = (s_d.cnt == '0);
      s_d.pec_slot = s_q.pec_en &&
                     (s_d.cnt == COUNT_W'(1));

      // notify pin falling edge
      s_d.note_prev = note_s;
      alert_ev = s_q.host_en & s_q.note_en &
                 s_q.note_prev & ~note_s;

      // sticky flags: clear first so a same-cycle event wins
      s_d.ovr_f   = (s_q.ovr_f & ~clr[SB_OVR]) | ovr_ev;
      s_d.pec_f   = (s_q.pec_f & ~clr[SB_PEC]) | pec_ev;
      s_d.tout_f  = (s_q.tout_f & ~clr[SB_TOUT]) | tout_ev;
      s_d.alert_f = (s_q.alert_f & ~clr[SB_ALERT]) | alert_ev;
      if (!s_d.tout_f) begin
         s_d.rel_hold = 1'b0;
      end

      // wakeup from stop on address match
      s_d.wake = stop_mode & s_q.wup_en & osc_internal &
                 s_q.on & addr_match_stb;

      // block off: reset state and flags, release lines
      if (!s_d.on) begin
         s_d.rx_full   = 1'b0;
         s_d.tx_empty  = 1'b1;
         s_d.ovr_f     = 1'b0;
         s_d.pec_f     = 1'b0;
         s_d.tout_f    = 1'b0;
         s_d.alert_f   = 1'b0;
         s_d.rel_hold  = 1'b0;
         s_d.cnt       = '0;
         s_d.done      = 1'b1;
         s_d.pec_slot  = 1'b0;
         s_d.low_cnt   = '0;
         s_d.ext_cnt   = '0;
         s_d.tx_stb    = 1'b0;
         s_d.nack      = 1'b0;
         s_d.auto_stop = 1'b0;
      end
      s_d.lines_rel = ~s_d.on | s_d.rel_hold;

      // requests and interrupt
      s_d.tx_rdy = s_d.tx_empty & tx_req & ~s_d.pec_slot &
                   ~s_d.done & s_d.on;
      s_d.txdma_req = s_d.txdma_en & s_d.tx_rdy;
      s_d.rxdma_req = s_d.rxdma_en & s_d.rx_full;
      s_d.err_irq = s_d.err_ie & (s_d.ovr_f | s_d.pec_f |
                    s_d.tout_f | s_d.alert_f);

      // read data
      stat[SB_TXE]   = s_q.tx_empty;
      stat[SB_TXRDY] = s_q.tx_rdy;
      stat[SB_RXF]   = s_q.rx_full;
      stat[SB_OVR]   = s_q.ovr_f;
      stat[SB_PEC]   = s_q.pec_f;
      stat[SB_TOUT]  = s_q.tout_f;
      stat[SB_ALERT] = s_q.alert_f;
      stat[SB_DONE]  = s_q.done;
      if (reg_rd) begin
         case (reg_addr)
            OFF_CTRL: begin
               s_d.rdata[CB_ON]    = s_q.on;
               s_d.rdata[CB_ERROR_IRQ_ENABLE] = s_q.err_ie;
               s_d.rdata[CB_TXDMA] = s_q.txdma_en;
               s_d.rdata[CB_RXDMA] = s_q.rxdma_en;
               s_d.rdata[CB_NOSTR] = s_q.nostr;
               s_d.rdata[CB_WUP]   = s_q.wup_en;
               s_d.rdata[CB_HOST]  = s_q.host_en;
               s_d.rdata[CB_NOTE]  = s_q.note_en;
               s_d.rdata[CB_PEC]   = s_q.pec_en;
            end
            OFF_CNT: begin
               s_d.rdata[COUNT_W-1:0] = s_q.cnt_cfg;
            end
            OFF_TOUT: begin
               s_d.rdata[TB_LOW_LSB +: LIMIT_W] = s_q.low_lim;
               s_d.rdata[TB_IDLE]   = s_q.idle_sel;
               s_d.rdata[TB_LOW_EN] = s_q.low_en;
               s_d.rdata[TB_EXT_LSB +: LIMIT_W] = s_q.ext_lim;
               s_d.rdata[TB_EXT_EN] = s_q.ext_en;
            end
            OFF_STAT: begin
               s_d.rdata = stat;
            end
            OFF_RXD: begin
               s_d.rdata[BYTE_W-1:0] = s_q.rxd;
            end
            OFF_DBG: begin
               s_d.rdata[DB_FRZ] = s_q.dbg_frz;
            end
            default: begin
               s_d.rdata = ZERO_WORD;
            end
         endcase
      end
   end

   // =====================================================================
   // registers
   // =====================================================================
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // =====================================================================
   // outputs
   // =====================================================================
   assign reg_rdata     = s_q.rdata;
   assign tx_byte       = s_q.tx_byte;
   assign tx_byte_stb   = s_q.tx_stb;
   assign force_nack    = s_q.nack;
   assign auto_stop     = s_q.auto_stop;
   assign lines_release = s_q.lines_rel;
   assign pec_slot      = s_q.pec_slot;
   assign xfer_done     = s_q.done;
   assign err_irq       = s_q.err_irq;
   assign tx_dma_req    = s_q.txdma_req;
   assign rx_dma_req    = s_q.rxdma_req;
   assign wake_req      = s_q.wake;
endmodule : i2e_top

// ===== src/i2e_pkg.sv
// constants and register map of the bus error, dma request and low-power block
package i2e_pkg;
   // =====================================================================
   // bus and clock
   // =====================================================================
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned BYTE_W        = 8;
   localparam int unsigned CLK_PERIOD_NS = 8;

   // =====================================================================
   // register byte addresses
   // =====================================================================
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CNT  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_TOUT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_CLR  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_RXD  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_TXD  = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_DBG  = 8'h1c;

   // =====================================================================
   // control_reg_one fields
   // =====================================================================
   localparam int unsigned CB_ON    = 0;
   localparam int unsigned CB_ERROR_IRQ_ENABLE = 7;
   localparam int unsigned CB_TXDMA = 14;
   localparam int unsigned CB_RXDMA = 15;
   localparam int unsigned CB_NOSTR = 17;
   localparam int unsigned CB_WUP   = 18;
   localparam int unsigned CB_HOST  = 20;
   localparam int unsigned CB_NOTE  = 22;
   localparam int unsigned CB_PEC   = 23;

   // =====================================================================
   // timeout register fields
   // =====================================================================
   localparam int unsigned TB_LOW_LSB = 0;
   localparam int unsigned TB_IDLE    = 12;
   localparam int unsigned TB_LOW_EN  = 15;
   localparam int unsigned TB_EXT_LSB = 16;
   localparam int unsigned TB_EXT_EN  = 31;

   // =====================================================================
   // status and clear fields, debug freeze bit
   // =====================================================================
   localparam int unsigned SB_TXE   = 0;
   localparam int unsigned SB_TXRDY = 1;
   localparam int unsigned SB_RXF   = 2;
   localparam int unsigned SB_OVR   = 3;
   localparam int unsigned SB_PEC   = 4;
   localparam int unsigned SB_TOUT  = 5;
   localparam int unsigned SB_ALERT = 6;
   localparam int unsigned SB_DONE  = 7;
   localparam int unsigned DB_FRZ   = 0;

   // =====================================================================
   // values and timing
   // =====================================================================
   localparam logic [BYTE_W-1:0] FILL_BYTE = 8'hff;
   localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
   localparam int unsigned TOUT_UNIT_NS = 64;
   localparam int unsigned UNIT_W       = 8;
   localparam logic [UNIT_W-1:0] UNIT_CYC = UNIT_W'(
      (TOUT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : i2e_pkg

// ===== src/i2e_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module i2e_sync #(
   parameter int unsigned W = 3
) (
   input  logic         mclk,  // kernel clock
   input  logic         nrst,  // async reset, active low
   input  logic [W-1:0] din,   // asynchronous inputs
   output logic [W-1:0] dout   // synchronised outputs
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } i2e_sync_s;
   i2e_sync_s s_q;
   i2e_sync_s s_d;
   always_comb begin
      s_d      = s_q;
      s_d.meta = din;
      s_d.stab = s_q.meta;
   end
   // pins idle high on the bus
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.stab;
endmodule : i2e_sync

// ===== sim/i2e_partner.sv
// far-side bus party: clock and data lines plus notify pin
`timescale 1ns/1ps
module i2e_partner (
   input  wire logic [1:0] mode,   // 0 idle, 1 clock held low, 2 frame
   input  wire logic       alert,  // pull notify low
   output logic            scl,    // clock line, 80 ns period in a frame
   output logic            sda,    // data line
   output logic            notify  // notify pin, pulled up
);
   initial scl = 1'h1;
   always #40 scl = (mode == 2'h2) ? ~scl : (mode != 2'h1);
   // data changes every half period in a frame, pulled up otherwise
   assign sda = (mode == 2'h2) ? ~scl : 1'h1;
   assign notify = ~alert;
endmodule : i2e_partner

// ===== sim/i2e_top_chk.sv
// output checks of the error, dma and wakeup block
`timescale 1ns/1ps
module i2e_top_chk
   import i2e_pkg::*;
(
   input logic              mclk,           // kernel clock
   input logic              nrst,           // reset, active low
   input logic              reg_rd,         // read strobe
   input logic [ADDR_W-1:0] reg_addr,       // address
   input logic [DATA_W-1:0] reg_rdata,      // read data
   input logic              is_master,      // master role
   input logic              stop_mode,      // stop mode
   input logic              osc_internal,   // internal oscillator
   input logic              addr_match_stb, // address match
   input logic              byte_rx_stb,    // byte received
   input logic              tx_due_stb,     // byte due
   input logic              tx_byte_stb,    // byte sent
   input logic              force_nack,     // nack pulse
   input logic              auto_stop,      // stop request
   input logic              pec_slot,       // check byte next
   input logic              xfer_done,      // counter empty
   input logic              wake_req        // wakeup pulse
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == ZERO_WORD)
      else $error("read data outside read slot");
   chk_read_wo: assert property ($past(reg_rd) && $past(reg_addr) == OFF_TXD
      |-> reg_rdata == ZERO_WORD) else $error("write-only place read back");
   chk_nack_cause: assert property (
      force_nack |-> $past(byte_rx_stb)) else $error("nack without byte");
   chk_tx_cause: assert property (
      tx_byte_stb |-> $past(tx_due_stb) && !$past(pec_slot))
      else $error("byte sent without due slot");
   chk_wake_cause: assert property (
      wake_req |-> $past(addr_match_stb && stop_mode && osc_internal))
      else $error("wakeup without match in stop");
   chk_stop_master: assert property (
      auto_stop |-> $past(is_master)) else $error("stop while not master");
   chk_stop_pulse: assert property (
      auto_stop |=> !auto_stop) else $error("stop request too long");
   chk_slot_count: assert property (
      pec_slot |-> !xfer_done) else $error("check slot at zero count");
endmodule : i2e_top_chk

bind i2e_top i2e_top_chk u_i2e_top_chk (.mclk, .nrst, .reg_rd, .reg_addr,
   .reg_rdata, .is_master, .stop_mode, .osc_internal, .addr_match_stb,
   .byte_rx_stb, .tx_due_stb, .tx_byte_stb, .force_nack, .auto_stop,
   .pec_slot, .xfer_done, .wake_req);

// ===== sim/test_i2e_top.sv
// self-checking bench of the error, dma and wakeup block
`timescale 1ns/1ps
module test_i2e_top;
   import i2e_pkg::*;
   logic mclk = 1'h0, nrst = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
   logic is_master = 1'h0, is_slave = 1'h0, tx_req = 1'h0, alert = 1'h0;
   logic stop_mode = 1'h0, osc_internal = 1'h0, dbg_halt = 1'h0;
   logic stop_detected = 1'h0, stretch_ext = 1'h0;
   logic [3:0] stb = 4'h0;
   logic [1:0] mode = 2'h0;
   logic [7:0] reg_addr = 8'h00, rx_byte = 8'h00, pec_value, tx_byte, v;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, c, d;
   logic scl_in, sda_in, notify_pin, tx_byte_stb, force_nack, auto_stop;
   logic lines_release, pec_slot, xfer_done, err_irq, tx_dma_req;
   logic rx_dma_req, wake_req;
   int seed = 10079, failures = 0, compares = 0, n;
   logic [7:0] rxq[$];
   wire [2:0] mon = {wake_req, lines_release, auto_stop};

   i2e_top u_i2e_top (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .scl_in, .sda_in, .notify_pin, .is_master, .is_slave,
      .start_stb(stb[0]), .byte_rx_stb(stb[1]), .rx_byte, .pec_value,
      .tx_req, .tx_due_stb(stb[2]), .stop_detected, .stretch_ext, .dbg_halt,
      .stop_mode, .osc_internal, .addr_match_stb(stb[3]), .tx_byte,
      .tx_byte_stb, .force_nack, .auto_stop, .lines_release, .pec_slot,
      .xfer_done, .err_irq, .tx_dma_req, .rx_dma_req, .wake_req);
   i2e_partner u_i2e_partner (.mode, .alert, .scl(scl_in), .sda(sda_in),
      .notify(notify_pin));

   always #4 mclk = ~mclk;

   function automatic logic [31:0] b(input int k);
      return 32'h1 << k;
   endfunction : b
   task automatic test_done;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic c1(input logic g, input logic e);
      cmp({31'h0, g}, {31'h0, e});
   endtask : c1
   task automatic idle(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1;
      d = reg_rdata;
   endtask : rd
   task automatic st(input int k, input logic e);
      rd(OFF_STAT);
      c1(d[k], e);
   endtask : st
   task automatic pulse(input logic [3:0] m, input logic [7:0] by);
      @(posedge mclk);
      stb <= m;
      rx_byte <= by;
      @(posedge mclk);
      stb <= 4'h0;
      #1;
   endtask : pulse
   task automatic wt(input int k);
      for (n = 0; n < 400 && mon[k] !== 1'h1; n++)
         idle(1);
      c1(mon[k], 1'h1);
      if (mon[k] !== 1'h1)
         test_done;
   endtask : wt

   initial begin
      pec_value = 8'($random(seed));
      repeat (3) @(posedge mclk);
      nrst <= 1'h1;
      is_slave <= 1'h1;
      tx_req <= 1'h1;
      c = b(CB_ON) | b(CB_ERROR_IRQ_ENABLE) | b(CB_NOSTR) | b(CB_TXDMA) | b(CB_RXDMA);
      wr(OFF_CTRL, c);
      rd(OFF_CTRL);
      cmp(d, c);
      rd(8'h20);
      cmp(d, ZERO_WORD);
      rd(OFF_CLR);
      cmp(d, ZERO_WORD);
      wr(OFF_CNT, 32'h4);
      pulse(4'h1, 8'h00);
      idle(3);
      c1(tx_dma_req, 1'h1);
      pulse(4'h4, 8'h00);
      cmp({24'h0, tx_byte}, 32'hff);
      st(SB_OVR, 1'h1);
      c1(err_irq, 1'h1);
      wr(OFF_CLR, b(SB_OVR));
      idle(2);
      c1(err_irq, 1'h0);
      $display("test 1 done");
      v = 8'($random(seed));
      wr(OFF_TXD, {24'h0, v});
      idle(3);
      c1(tx_dma_req, 1'h0);
      pulse(4'h4, 8'h00);
      cmp({24'h0, tx_byte}, {24'h0, v});
      st(SB_OVR, 1'h0);
      for (int i = 0; i < 2; i++) begin
         v = 8'($random(seed));
         if (i == 0)
            rxq.push_back(v);
         pulse(4'h2, v);
         c1(force_nack, i == 1);
      end
      c1(rx_dma_req, 1'h1);
      rd(OFF_RXD);
      cmp(d, {24'h0, rxq.pop_front()});
      wr(OFF_CLR, b(SB_OVR));
      $display("test 2 done");
      c = c | b(CB_PEC);
      wr(OFF_CTRL, c);
      wr(OFF_CNT, 32'h2);
      pulse(4'h1, 8'h00);
      c1(pec_slot, 1'h0);
      pulse(4'h2, 8'h5a);
      rd(OFF_RXD);
      c1(pec_slot, 1'h1);
      pulse(4'h2, ~pec_value);
      c1(force_nack, 1'h1);
      st(SB_PEC, 1'h1);
      c1(xfer_done, 1'h1);
      c1(rx_dma_req, 1'h1);
      $display("test 3 done");
      @(posedge mclk);
      is_slave <= 1'h0;
      is_master <= 1'h1;
      mode <= 2'h1;
      wr(OFF_TOUT, 32'h2 | b(TB_LOW_EN));
      wt(0);
      c1(n >= UNIT_CYC && n <= 4 * UNIT_CYC, 1'h1);
      st(SB_TOUT, 1'h1);
      c1(lines_release, 1'h0);
      @(posedge mclk);
      mode <= 2'h0;
      is_master <= 1'h0;
      is_slave <= 1'h1;
      wr(OFF_CLR, b(SB_TOUT));
      wr(OFF_TOUT, 32'h3 | b(TB_IDLE) | b(TB_LOW_EN));
      wt(1);
      @(posedge mclk);
      mode <= 2'h2;
      wr(OFF_CLR, b(SB_TOUT));
      idle(2);
      c1(lines_release, 1'h0);
      wr(OFF_TOUT, (32'h2 << TB_EXT_LSB) | b(TB_EXT_EN));
      stretch_ext <= 1'h1;
      wt(1);
      $display("test 4 done");
      c = c | b(CB_HOST) | b(CB_NOTE) | b(CB_WUP);
      wr(OFF_CTRL, c);
      @(posedge mclk);
      alert <= 1'h1;
      stop_mode <= 1'h1;
      osc_internal <= 1'h1;
      idle(6);
      st(SB_ALERT, 1'h1);
      pulse(4'h8, 8'h00);
      c1(wake_req, 1'h1);
      wr(OFF_CTRL, ZERO_WORD);
      idle(2);
      c1(lines_release, 1'h1);
      st(SB_ALERT, 1'h0);
      $display("test 5 done");
      test_done;
   end
endmodule : test_i2e_top
